// ---- hw/isvm_top.sv ----
// Interrupt request mapper, level registers and vector selector
//
// Operation
// - Timer ch0 lower raises 5, vector FFF0/FFF1
// - Timer ch0 upper raises 6, vector FFEE/FFEF
// - Pulse generator ch1 lower raises 9, FFE8/FFE9
// - Pulse generator ch1 upper raises 10, FFE6/FFE7
// - Pulse generator ch0 upper raises 12, FFE2/FFE3
// - Pulse generator ch0 lower raises 13, FFE0/FFE1
// - Timer ch1 upper raises 14, vector FFDE/FFDF
// - Timer ch1 lower raises 22, vector FFCE/FFCF
// - Equal levels: lowest request number wins
// - Each request has its own two-bit level
// - Six level bytes from 0079, reset ones
`timescale 1ns/1ns
`default_nettype none

module isvm_top
   import isvm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // Peripheral request levels, same clock
   input wire logic [7:0] ext_irq,
   input wire logic uart_sio_irq,
   input wire logic ct0_lo_irq,
   input wire logic ct0_hi_irq,
   input wire logic lin_rx_irq,
   input wire logic lin_tx_irq,
   input wire logic pg1_lo_irq,
   input wire logic pg1_hi_irq,
   input wire logic pg0_hi_irq,
   input wire logic pg0_lo_irq,
   input wire logic ct1_hi_irq,
   input wire logic pg16_irq,
   input wire logic i2c_irq,
   input wire logic adc_irq,
   input wire logic tbt_irq,
   input wire logic watch_irq,
   input wire logic ct1_lo_irq,
   input wire logic flash_irq,
   // Core byte access to the level registers
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Selected request towards the core
   output logic irq_valid,
   output logic [NUM_W-1:0] irq_num,
   output logic [LVL_W-1:0] irq_level,
   output logic [15:0] vec_hi_addr,
   output logic [15:0] vec_lo_addr
);

   // ************************************************************
   // Request vector
   // ************************************************************
   logic [NUM_REQ-1:0] req;

   // Pairs of external channels share one request line
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ext
         assign req[REQ_EXT0+g] = ext_irq[g] | ext_irq[g+4];
      end
   endgenerate

   assign req[REQ_UART_SIO] = uart_sio_irq;
   assign req[REQ_CT0_LO] = ct0_lo_irq;
   assign req[REQ_CT0_HI] = ct0_hi_irq;
   assign req[REQ_LIN_RX] = lin_rx_irq;
   assign req[REQ_LIN_TX] = lin_tx_irq;
   assign req[REQ_PG1_LO] = pg1_lo_irq;
   assign req[REQ_PG1_HI] = pg1_hi_irq;
   assign req[11] = 1'b0;
   assign req[REQ_PG0_HI] = pg0_hi_irq;
   assign req[REQ_PG0_LO] = pg0_lo_irq;
   assign req[REQ_CT1_HI] = ct1_hi_irq;
   assign req[REQ_PG16] = pg16_irq;
   assign req[REQ_I2C] = i2c_irq;
   assign req[17] = 1'b0;
   assign req[REQ_ADC] = adc_irq;
   assign req[REQ_TBT] = tbt_irq;
   assign req[REQ_WATCH] = watch_irq;
   assign req[21] = 1'b0;
   assign req[REQ_CT1_LO] = ct1_lo_irq;
   assign req[REQ_FLASH] = flash_irq;

   // ************************************************************
   // Vector address of a request number
   // ************************************************************
   function automatic logic [15:0] vec_of(input logic [NUM_W-1:0] n);
      logic [15:0] ofs;
      logic [15:0] v;
      ofs = 16'({11'h000, n}) * VEC_STEP;
      v = VEC_TOP_HI - ofs;
      // Timer and pulse sources take their fixed table entries
      case (n)
         5'(REQ_CT0_LO): begin
            v = VEC_CT0_LO_HI;
         end
         5'(REQ_CT0_HI): begin
            v = VEC_CT0_HI_HI;
         end
         5'(REQ_PG1_LO): begin
            v = VEC_PG1_LO_HI;
         end
         5'(REQ_PG1_HI): begin
            v = VEC_PG1_HI_HI;
         end
         5'(REQ_PG0_HI): begin
            v = VEC_PG0_HI_HI;
         end
         5'(REQ_PG0_LO): begin
            v = VEC_PG0_LO_HI;
         end
         5'(REQ_CT1_HI): begin
            v = VEC_CT1_HI_HI;
         end
         5'(REQ_CT1_LO): begin
            v = VEC_CT1_LO_HI;
         end
         default: begin
            v = VEC_TOP_HI - ofs;
         end
      endcase
      return v;
   endfunction : vec_of

   // ************************************************************
   // Current and next state
   // ************************************************************
   isvm_state_t s_q;
   isvm_state_t s_d;

   // ************************************************************
   // Level register select and per-request level fields
   // ************************************************************
   logic [NUM_ILR-1:0] reg_sel;
   logic [NUM_REQ-1:0][LVL_W-1:0] req_lvl;

   generate
      for (g = 0; g < NUM_ILR; g++) begin : g_sel
         assign reg_sel[g] = (reg_addr == ILR_BASE_ADDR + 16'(g));
      end
      for (g = 0; g < NUM_REQ; g++) begin : g_lvl
         assign req_lvl[g] = s_q.ilr[g / FIELDS_PER_REG][(g % FIELDS_PER_REG) * LVL_W +: LVL_W];
      end
   endgenerate

   always_comb begin
      logic found;
      logic [NUM_W-1:0] best_n;
      logic [LVL_W-1:0] best_l;
      logic [LVL_W-1:0] lvl;
      found = 1'b0;
      best_n = '0;
      best_l = '1;
      lvl = '0;
      s_d = s_q;

      // Byte writes; a read answers one cycle later
      s_d.rdata = RDATA_UNMAPPED;
      for (int k = 0; k < NUM_ILR; k++) begin
         if (reg_sel[k]) begin
            s_d.rdata = s_q.ilr[k];
            if (reg_wr) begin
               s_d.ilr[k] = reg_wdata;
            end
         end
      end

      // Lowest level value wins; strict compare keeps the lower number
      for (int n = 0; n < NUM_REQ; n++) begin
         lvl = req_lvl[n];
         if (req[n] && (!found || lvl < best_l)) begin
            found = 1'b1;
            best_n = NUM_W'(n);
            best_l = lvl;
         end
      end

      s_d.valid = found;
      s_d.num = best_n;
      s_d.level = best_l;
      s_d.vec_hi = vec_of(best_n);
      s_d.vec_lo = vec_of(best_n) + VEC_LO_OFS;
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q.ilr <= {NUM_ILR{ILR_RESET}};
         s_q.rdata <= RDATA_UNMAPPED;
         s_q.valid <= 1'b0;
         s_q.num <= '0;
         s_q.level <= '0;
         s_q.vec_hi <= VEC_TOP_HI;
         s_q.vec_lo <= VEC_TOP_HI + VEC_LO_OFS;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign irq_valid = s_q.valid;
   assign irq_num = s_q.num;
   assign irq_level = s_q.level;
   assign vec_hi_addr = s_q.vec_hi;
   assign vec_lo_addr = s_q.vec_lo;

endmodule : isvm_top

`default_nettype wire

// ---- hw/isvm_pkg.sv ----
// Constants for the interrupt source vector map
package isvm_pkg;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int unsigned NUM_REQ = 24;
   localparam int unsigned NUM_ILR = 6;
   localparam int unsigned LVL_W = 2;
   localparam int unsigned NUM_W = 5;
   localparam int unsigned FIELDS_PER_REG = 4;

   // ************************************************************
   // Level register map and reset value
   // ************************************************************
   localparam logic [15:0] ILR_BASE_ADDR = 16'h0079;
   localparam logic [7:0] ILR_RESET = 8'hff;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // ************************************************************
   // Vector table: request n has upper byte at BASE - 2n
   // ************************************************************
   localparam logic [15:0] VEC_TOP_HI = 16'hfffa;
   localparam logic [15:0] VEC_STEP = 16'h0002;
   localparam logic [15:0] VEC_LO_OFS = 16'h0001;

   // ************************************************************
   // Request numbers of each source
   // ************************************************************
   localparam int unsigned REQ_EXT0 = 0;
   localparam int unsigned REQ_UART_SIO = 4;
   localparam int unsigned REQ_CT0_LO = 5;
   localparam int unsigned REQ_CT0_HI = 6;
   localparam int unsigned REQ_LIN_RX = 7;
   localparam int unsigned REQ_LIN_TX = 8;
   localparam int unsigned REQ_PG1_LO = 9;
   localparam int unsigned REQ_PG1_HI = 10;
   localparam int unsigned REQ_PG0_HI = 12;
   localparam int unsigned REQ_PG0_LO = 13;
   localparam int unsigned REQ_CT1_HI = 14;
   localparam int unsigned REQ_PG16 = 15;
   localparam int unsigned REQ_I2C = 16;
   localparam int unsigned REQ_ADC = 18;
   localparam int unsigned REQ_TBT = 19;
   localparam int unsigned REQ_WATCH = 20;
   localparam int unsigned REQ_CT1_LO = 22;
   localparam int unsigned REQ_FLASH = 23;

   // Fixed vector addresses of the timer and pulse generator sources
   localparam logic [15:0] VEC_CT0_LO_HI = 16'hfff0;
   localparam logic [15:0] VEC_CT0_HI_HI = 16'hffee;
   localparam logic [15:0] VEC_PG1_LO_HI = 16'hffe8;
   localparam logic [15:0] VEC_PG1_HI_HI = 16'hffe6;
   localparam logic [15:0] VEC_PG0_HI_HI = 16'hffe2;
   localparam logic [15:0] VEC_PG0_LO_HI = 16'hffe0;
   localparam logic [15:0] VEC_CT1_HI_HI = 16'hffde;
   localparam logic [15:0] VEC_CT1_LO_HI = 16'hffce;

   // ************************************************************
   // Module state
   // ************************************************************
   typedef struct packed {
      logic [NUM_ILR-1:0][7:0] ilr;
      logic [7:0] rdata;
      logic valid;
      logic [NUM_W-1:0] num;
      logic [LVL_W-1:0] level;
      logic [15:0] vec_hi;
      logic [15:0] vec_lo;
   } isvm_state_t;

endpackage : isvm_pkg

// ---- test/isvm_props.sv ----
// Assertion checker for the interrupt source vector map
`timescale 1ns/1ns
`default_nettype none
module isvm_props
   import isvm_pkg::*;
(
   input wire logic clk, rst, ct0_lo_irq, uart_sio_irq, reg_wr, irq_valid,
   input wire logic [7:0] ext_irq, reg_wdata, reg_rdata,
   input wire logic [15:0] reg_addr, vec_hi_addr, vec_lo_addr,
   input wire logic [NUM_W-1:0] irq_num,
   input wire logic [LVL_W-1:0] irq_level
);
   wire logic mapped = reg_addr >= ILR_BASE_ADDR && reg_addr <= ILR_BASE_ADDR + 16'h0005;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ****
   // Properties
   // ****
   a_rd_unmapped:
      assert property (!mapped |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_rd_written:
      assert property (reg_wr && mapped ##1 $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
      else $error("written level byte not read back");
   a_vec_formula:
      assert property (vec_hi_addr == 16'hfffa - {10'h000, irq_num, 1'b0}
         && vec_lo_addr == vec_hi_addr + 16'h0001) else $error("vector pair off");
   a_ct1_lo_vec:
      assert property (irq_num == 5'd22 |-> vec_hi_addr == 16'hffce && vec_lo_addr == 16'hffcf)
      else $error("request 22 vector wrong");
   a_ct0_lo_vec:
      assert property (irq_num == 5'd5 |-> vec_hi_addr == 16'hfff0 && vec_lo_addr == 16'hfff1)
      else $error("request 5 vector wrong");
   a_ct0_hi_vec:
      assert property (irq_num == 5'd6 |-> vec_hi_addr == 16'hffee && vec_lo_addr == 16'hffef)
      else $error("request 6 vector wrong");
   a_pg1_lo_vec:
      assert property (irq_num == 5'd9 |-> vec_hi_addr == 16'hffe8 && vec_lo_addr == 16'hffe9)
      else $error("request 9 vector wrong");
   a_pg1_hi_vec:
      assert property (irq_num == 5'd10 |-> vec_hi_addr == 16'hffe6 && vec_lo_addr == 16'hffe7)
      else $error("request 10 vector wrong");
   a_pg0_hi_vec:
      assert property (irq_num == 5'd12 |-> vec_hi_addr == 16'hffe2 && vec_lo_addr == 16'hffe3)
      else $error("request 12 vector wrong");
   a_ct1_hi_vec:
      assert property (irq_num == 5'd14 |-> vec_hi_addr == 16'hffde && vec_lo_addr == 16'hffdf)
      else $error("request 14 vector wrong");
   a_pg0_lo_vec:
      assert property (irq_num == 5'd13 |-> vec_hi_addr == 16'hffe0 && vec_lo_addr == 16'hffe1)
      else $error("request 13 vector wrong");
   a_unused_quiet:
      assert property (irq_valid |-> !(irq_num inside {5'd11, 5'd17, 5'd21}))
      else $error("unused request selected");
   a_low_num_wins:
      assert property ((ext_irq[0] | ext_irq[4]) |=> irq_valid && (irq_level != 2'h3 || irq_num == 5'd0))
      else $error("request 0 lost a tie");
   a_ct0_lo_rank:
      assert property (ct0_lo_irq && ext_irq == 8'h00 && !uart_sio_irq
         |=> irq_valid && (irq_level != 2'h3 || irq_num == 5'd5)) else $error("request 5 lost a tie");
   c_tie_pick: cover property (irq_valid && irq_num == 5'd5 && irq_level == 2'h3);
   c_write: cover property (reg_wr && mapped);
   c_top_level: cover property (irq_valid && irq_level == 2'h0);
endmodule : isvm_props
bind isvm_top isvm_props u_props (.clk, .rst, .ext_irq, .ct0_lo_irq, .uart_sio_irq, .reg_addr,
   .reg_wr, .reg_wdata, .reg_rdata, .irq_valid, .irq_num, .irq_level, .vec_hi_addr, .vec_lo_addr);
`default_nettype wire

// ---- test/isvm_core_model.sv ----
// Core-side model that takes the selected vector pair
`timescale 1ns/1ns
`default_nettype none
module isvm_core_model
   import isvm_pkg::*;
(
   input wire logic clk,
   input wire logic irq_valid,
   input wire logic [15:0] vec_hi_addr,
   input wire logic [15:0] vec_lo_addr,
   output logic [15:0] fetch_q
);
   // Only a pair of adjacent bytes is a usable vector
   always_ff @(posedge clk) begin
      if (irq_valid) begin
         fetch_q <= (vec_lo_addr == vec_hi_addr + 16'h0001) ? vec_hi_addr : 16'h0000;
      end
   end
endmodule : isvm_core_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Random and corner-case bench for the interrupt source vector map
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import isvm_pkg::*;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, vld;
   logic [7:0] ext = 8'h00, wdat = 8'h00, rdata;
   logic [23:0] src = 24'h000000;
   logic [15:0] addr = 16'h0000, vhi, vlo, seed = 16'h0045, exp_q = 16'h0300;
   logic [4:0] num;
   logic [1:0] lvl;
   logic [7:0] lv [NUM_ILR] = '{default: 8'hff};
   int miscompares = 0, tests_run = 0;
   always #25 clk = ~clk;
   isvm_top dut (.clk(clk), .rst(rst), .ext_irq(ext), .uart_sio_irq(src[4]), .ct0_lo_irq(src[5]),
      .ct0_hi_irq(src[6]), .lin_rx_irq(src[7]), .lin_tx_irq(src[8]), .pg1_lo_irq(src[9]),
      .pg1_hi_irq(src[10]), .pg0_hi_irq(src[12]), .pg0_lo_irq(src[13]), .ct1_hi_irq(src[14]),
      .pg16_irq(src[15]), .i2c_irq(src[16]), .adc_irq(src[18]), .tbt_irq(src[19]),
      .watch_irq(src[20]), .ct1_lo_irq(src[22]), .flash_irq(src[23]), .reg_addr(addr),
      .reg_wr(wr), .reg_wdata(wdat), .reg_rdata(rdata), .irq_valid(vld), .irq_num(num),
      .irq_level(lvl), .vec_hi_addr(vhi), .vec_lo_addr(vlo));
   isvm_core_model core (.clk(clk), .irq_valid(vld), .vec_hi_addr(vhi), .vec_lo_addr(vlo),
      .fetch_q());
   // ****
   // Expectations
   // ****
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr
   function automatic logic in_map(input logic [15:0] a);
      return a >= ILR_BASE_ADDR && a <= ILR_BASE_ADDR + 16'h0005;
   endfunction : in_map
   // Scan from the top so that ties settle on the lowest number
   function automatic logic [15:0] expect_sel(input logic [7:0] e, input logic [23:0] s,
      input logic [15:0] a);
      logic [23:0] r;
      logic [15:0] x;
      r = (s & 24'hddf7f0) | {20'h00000, e[3:0] | e[7:4]};
      x = 16'h0300;
      for (int n = 23; n >= 0; n--) begin
         if (r[n] && lv[n / 4][2 * (n % 4) +: 2] <= x[9:8]) begin
            x[15:8] = {1'b1, 5'(n), lv[n / 4][2 * (n % 4) +: 2]};
         end
      end
      if (in_map(a)) begin
         x[7:0] = lv[a - ILR_BASE_ADDR];
      end
      return x;
   endfunction : expect_sel
   task automatic step(input logic [7:0] e, input logic [23:0] s, input logic [15:0] a,
      input logic w, input logic [7:0] d);
      @(posedge clk);
      ext <= e;
      src <= s;
      addr <= a;
      wr <= w;
      wdat <= d;
      #1;
      tests_run++;
      if ({vld, num, lvl, rdata} !== exp_q || vhi !== 16'hfffa - {exp_q[14:10], 1'b0}
         || vlo !== vhi + 16'h0001) begin
         $display("BAD %0t got %h exp %h vec %h", $time, {vld, num, lvl, rdata}, exp_q, vhi);
         miscompares++;
      end
      exp_q = expect_sel(e, s, a);
      if (w && in_map(a)) begin
         lv[a - ILR_BASE_ADDR] = d;
      end
   endtask : step
   task automatic tally_and_finish();
      if (miscompares == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) step(8'h00, 24'h0, 16'h0078 + 16'(i), 1'b0, 8'h00);
      step(8'h00, 24'h002020, 16'h007c, 1'b1, 8'hf3);
      repeat (3) step(8'h00, 24'h002020, 16'h007c, 1'b0, 8'h00);
      for (int n = 0; n < 24; n++) step(n < 4 ? 8'h10 << n : 8'h00, 24'h1 << n, 16'h0, 1'b0, 8'h0);
      for (int k = 0; k < 6; k++) step(8'h00, 24'h0, ILR_BASE_ADDR + 16'(k), 1'b1, 8'h55);
      step(8'hff, 24'hffffff, 16'h0, 1'b0, 8'h00);
      step(8'h00, 24'hfffff0, 16'h0, 1'b0, 8'h00);
      repeat (3000) begin
         seed = lfsr(lfsr(lfsr(seed)));
         step(seed[15:8] & seed[7:0], {seed[7:0], seed} & {seed[3:0], seed, seed[15:12]},
            {12'h007, seed[11:8]}, seed[12] & seed[5], seed[7:0] ^ seed[15:8]);
      end
      step(8'h00, 24'h0, 16'h0, 1'b0, 8'h00);
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
